// ==== core/mlcs_map.svh ====
// Register indices, field positions and reset values of the limit block
`ifndef MLCS_MAP_SVH
`define MLCS_MAP_SVH
// Register indices; byte address is four times the index
`define MLCS_IDX_FE_LIM 6'h16
`define MLCS_IDX_FE_LIM_HI 6'h17
`define MLCS_IDX_CMD 6'h18
`define MLCS_IDX_STAT 6'h19
`define MLCS_IDX_TEMP 6'h1A
`define MLCS_IDX_NEG_LIM 6'h1C
`define MLCS_IDX_NEG_LIM_HI 6'h1D
`define MLCS_IDX_POS_LIM 6'h1E
`define MLCS_IDX_POS_LIM_HI 6'h1F
`define MLCS_IDX_ERR 6'h23
`define MLCS_IDX_IRQ_ST 6'h24
`define MLCS_IDX_IRQ_MK 6'h25
// Reset values
`define MLCS_RST_WORD 32'h0000_0000
`define MLCS_RST_NIB 4'h0
// Implemented run status bits 1-9 and 14-24
`define MLCS_STAT_MASK 32'h01FF_C3FE
// Error flag bits
`define MLCS_ERR_GEN 0
`define MLCS_ERR_FLW 1
`define MLCS_ERR_POS 3
// Interrupt status bits
`define MLCS_IRQ_FLW 0
`define MLCS_IRQ_POS 1
`define MLCS_IRQ_CMD 2
`define MLCS_IRQ_BAD 3
// Command code ranges
`define MLCS_CMD_FAST_MAX 32'h0000_007F
`define MLCS_CMD_OTHER_MIN 32'h0000_0100
`endif

// ==== core/mlcs_pkg.sv ====
// Types shared by the limit, command and status block
package mlcs_pkg;
    // Class of a written command code
    typedef enum logic [1:0] {
        MLCS_CMD_FAST,
        MLCS_CMD_OTHER,
        MLCS_CMD_BAD
    } mlcs_cmd_e;

    // Complete state of the block
    typedef struct packed {
        logic [31:0] fe_lim;
        logic [31:0] neg_lim;
        logic [31:0] pos_lim;
        logic [31:0] cmd;
        logic [31:0] stat;
        logic [31:0] temp;
        logic [3:0] err;
        logic [3:0] irq_st;
        logic [3:0] irq_mk;
        logic [31:0] rdata;
        logic irq;
        logic fe_act;
        logic pl_act;
        logic cmd_valid;
        logic cmd_fast;
        logic cmd_other;
    } mlcs_state_s;
endpackage

// ==== core/mlcs_core.sv ====
// Follow error limit, command, run status, temperature and soft limits
//
// Functional notes
// - Follow error raised when deviation exceeds the signed 32-bit limit, default zero.
// - A zero follow error limit disables the follow error entirely.
// - Command register write issues code; 0-127 fast set, 256 upward others.
// - Run status bits 1-7 report retry, positions, velocity, ramps, zero search.
// - Bit 8 password lock, bit 9 magnetic encoder error, bits 10-13 zero.
// - Bits 14-17 report brake, lead/lag, closed loop, encoder calibrated.
// - Bits 18-22 report standby current, memory, encoder, sync, target position.
// - Bits 23 and 24 report both safe torque off channels; 25-31 zero.
// - Read-only register returns the raw scaled motor temperature.
// - Negative soft position limit, signed 32 bits, read-write, reset zero.
// - Positive soft position limit, signed 32 bits, read-write, reset zero.
// - Upper word slot after each limit is reserved and reads zero.
// - Compared value is encoder deviation from the calculated actual position.
// - Follow error sets error bit 1, limit violation bit 3, both bit 0.
//
// Strobed register access was decided locally.
`timescale 1ns/100ps
`include "mlcs_map.svh"

module mlcs_core (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic [31:0] follow_error_value,
    input wire logic [31:0] actual_position,
    input wire logic [31:0] motor_status_bits,
    input wire logic [31:0] temperature_raw,
    output logic follow_error,
    output logic limit_violation,
    output logic [31:0] command_code,
    output logic command_valid,
    output logic command_fast,
    output logic command_other,
    output logic [3:0] error_flags,
    output logic irq
);

    // Magnitude of a signed word, widened so the most negative value fits
    function automatic logic signed [32:0] mag33(input logic [31:0] v);
        logic signed [32:0] w;
        w = {v[31], v};
        mag33 = w[32] ? -w : w;
    endfunction

    // Sorts a command code into fast, other or rejected
    function automatic mlcs_pkg::mlcs_cmd_e cmd_class(input logic [31:0] c);
        if (c <= `MLCS_CMD_FAST_MAX) begin
            cmd_class = mlcs_pkg::MLCS_CMD_FAST;
        end else if (c >= `MLCS_CMD_OTHER_MIN) begin
            cmd_class = mlcs_pkg::MLCS_CMD_OTHER;
        end else begin
            cmd_class = mlcs_pkg::MLCS_CMD_BAD;
        end
    endfunction

    mlcs_pkg::mlcs_state_s q;
    mlcs_pkg::mlcs_state_s next_q;

    logic [5:0] idx;
    logic wr_hit_cmd;
    logic rd_hit_st;
    logic fe_cond;
    logic pl_cond;
    logic [3:0] irq_set;
    logic [3:0] err_set;
    mlcs_pkg::mlcs_cmd_e wclass;

    // Word index from the byte address
    assign idx = reg_addr[7:2];
    assign wr_hit_cmd = reg_wr && (idx == `MLCS_IDX_CMD);
    assign rd_hit_st = reg_rd && (idx == `MLCS_IDX_IRQ_ST);
    assign wclass = cmd_class(reg_wdata);

    // Follow error and soft limit conditions
    always_comb begin
        // Deviation magnitude against the limit, zero limit disables
        // Signed compare, so a negative limit is exceeded by any magnitude
        fe_cond = (q.fe_lim != `MLCS_RST_WORD) &&
                  (mag33(follow_error_value) >
                   $signed({q.fe_lim[31], q.fe_lim}));
        // Both limits zero leave the position unchecked
        pl_cond = ((q.neg_lim != `MLCS_RST_WORD) || (q.pos_lim != `MLCS_RST_WORD)) &&
                  (($signed(actual_position) > $signed(q.pos_lim)) ||
                   ($signed(actual_position) < $signed(q.neg_lim)));
    end

    // Error and interrupt events
    always_comb begin
        err_set = `MLCS_RST_NIB;
        irq_set = `MLCS_RST_NIB;
        if (fe_cond) begin
            err_set[`MLCS_ERR_FLW] = 1'b1;
            err_set[`MLCS_ERR_GEN] = 1'b1;
        end
        if (pl_cond) begin
            err_set[`MLCS_ERR_POS] = 1'b1;
            err_set[`MLCS_ERR_GEN] = 1'b1;
        end
        irq_set[`MLCS_IRQ_FLW] = fe_cond && !q.fe_act;
        irq_set[`MLCS_IRQ_POS] = pl_cond && !q.pl_act;
        irq_set[`MLCS_IRQ_CMD] = wr_hit_cmd && (wclass != mlcs_pkg::MLCS_CMD_BAD);
        irq_set[`MLCS_IRQ_BAD] = wr_hit_cmd && (wclass == mlcs_pkg::MLCS_CMD_BAD);
    end

    // Next state of the whole block
    always_comb begin
        next_q = q;
        next_q.fe_act = fe_cond;
        next_q.pl_act = pl_cond;
        next_q.stat = motor_status_bits & `MLCS_STAT_MASK;
        next_q.temp = temperature_raw;
        next_q.cmd_valid = 1'b0;
        next_q.cmd_fast = 1'b0;
        next_q.cmd_other = 1'b0;
        next_q.rdata = `MLCS_RST_WORD;
        next_q.err = q.err | err_set;
        // Register writes
        if (reg_wr) begin
            case (idx)
                `MLCS_IDX_FE_LIM: next_q.fe_lim = reg_wdata;
                `MLCS_IDX_NEG_LIM: next_q.neg_lim = reg_wdata;
                `MLCS_IDX_POS_LIM: next_q.pos_lim = reg_wdata;
                `MLCS_IDX_CMD: begin
                    next_q.cmd = reg_wdata;
                    next_q.cmd_valid = 1'b1;
                    next_q.cmd_fast = (wclass == mlcs_pkg::MLCS_CMD_FAST);
                    next_q.cmd_other = (wclass == mlcs_pkg::MLCS_CMD_OTHER);
                end
                // Write one to clear, a new event wins
                `MLCS_IDX_ERR: next_q.err = (q.err & ~reg_wdata[3:0]) | err_set;
                `MLCS_IDX_IRQ_MK: next_q.irq_mk = reg_wdata[3:0];
                default: next_q.cmd_valid = 1'b0;
            endcase
        end
        // Register reads, answered in the following cycle
        if (reg_rd) begin
            case (idx)
                `MLCS_IDX_FE_LIM: next_q.rdata = q.fe_lim;
                `MLCS_IDX_CMD: next_q.rdata = q.cmd;
                `MLCS_IDX_STAT: next_q.rdata = q.stat;
                `MLCS_IDX_TEMP: next_q.rdata = q.temp;
                `MLCS_IDX_NEG_LIM: next_q.rdata = q.neg_lim;
                `MLCS_IDX_POS_LIM: next_q.rdata = q.pos_lim;
                `MLCS_IDX_ERR: next_q.rdata = {28'h000_0000, q.err};
                `MLCS_IDX_IRQ_ST: next_q.rdata = {28'h000_0000, q.irq_st};
                `MLCS_IDX_IRQ_MK: next_q.rdata = {28'h000_0000, q.irq_mk};
                // Upper words and unmapped indices read zero
                default: next_q.rdata = `MLCS_RST_WORD;
            endcase
        end
        // Read clears status, a new event wins
        next_q.irq_st = (rd_hit_st ? `MLCS_RST_NIB : q.irq_st) | irq_set;
        next_q.irq = |(next_q.irq_st & next_q.irq_mk);
    end

    // State register
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    // Outputs straight from the state
    assign reg_rdata = q.rdata;
    assign follow_error = q.fe_act;
    assign limit_violation = q.pl_act;
    assign command_code = q.cmd;
    assign command_valid = q.cmd_valid;
    assign command_fast = q.cmd_fast;
    assign command_other = q.cmd_other;
    assign error_flags = q.err;
    assign irq = q.irq;

    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    fe_trip_a: assert property ((q.fe_lim != `MLCS_RST_WORD) &&
        (mag33(follow_error_value) > $signed({q.fe_lim[31], q.fe_lim})) |=>
        follow_error)
        else $error("follow error not raised");

    // Deviation inside the limit leaves the error low
    fe_drop_a: assert property (
        (mag33(follow_error_value) <= $signed({q.fe_lim[31], q.fe_lim})) |=>
        !follow_error)
        else $error("follow error without excess deviation");

    // Limit register takes the written word
    fe_lim_wr_a: assert property ((reg_wr && idx == `MLCS_IDX_FE_LIM) |=>
        q.fe_lim == $past(reg_wdata))
        else $error("follow limit write lost");

    fe_zero_off_a: assert property ((q.fe_lim == `MLCS_RST_WORD) |=> !follow_error)
        else $error("follow error raised with zero limit");

    fe_flags_a: assert property (follow_error |-> error_flags[`MLCS_ERR_FLW] &&
        error_flags[`MLCS_ERR_GEN])
        else $error("follow error flag missing");

    pl_flags_a: assert property (limit_violation |-> error_flags[`MLCS_ERR_POS] &&
        error_flags[`MLCS_ERR_GEN])
        else $error("limit flag missing");

    cmd_issue_a: assert property (wr_hit_cmd |=> command_valid &&
        (command_code == $past(reg_wdata)) && (command_fast == ($past(reg_wdata) <=
        `MLCS_CMD_FAST_MAX)))
        else $error("command not issued");

    stat_word_a: assert property ((reg_rd && idx == `MLCS_IDX_STAT) |=>
        reg_rdata == ($past(motor_status_bits, 2) & `MLCS_STAT_MASK))
        else $error("run status mismatch");

    stat_rsvd_a: assert property ((reg_rd && idx == `MLCS_IDX_STAT) |=>
        (reg_rdata & ~`MLCS_STAT_MASK) == `MLCS_RST_WORD)
        else $error("reserved status bits set");

    temp_read_a: assert property ((reg_rd && idx == `MLCS_IDX_TEMP) |=>
        reg_rdata == $past(temperature_raw, 2))
        else $error("temperature mismatch");

    neg_lim_a: assert property ((reg_wr && idx == `MLCS_IDX_NEG_LIM) ##1
        (reg_rd && idx == `MLCS_IDX_NEG_LIM && !reg_wr) |=>
        reg_rdata == $past(reg_wdata, 2))
        else $error("negative limit readback");

    pos_lim_a: assert property ((reg_wr && idx == `MLCS_IDX_POS_LIM) ##1
        (reg_rd && idx == `MLCS_IDX_POS_LIM && !reg_wr) |=>
        reg_rdata == $past(reg_wdata, 2))
        else $error("positive limit readback");

    hi_zero_a: assert property (reg_rd && (idx == `MLCS_IDX_FE_LIM_HI ||
        idx == `MLCS_IDX_NEG_LIM_HI || idx == `MLCS_IDX_POS_LIM_HI) |=>
        reg_rdata == `MLCS_RST_WORD)
        else $error("reserved upper word not zero");

    irq_level_a: assert property ($rose(follow_error) && q.irq_mk[`MLCS_IRQ_FLW] |-> irq)
        else $error("interrupt missing");

    // Read data stands one cycle only
    rdata_idle_a: assert property (!reg_rd |=> reg_rdata == `MLCS_RST_WORD)
        else $error("read data outside its cycle");

    // Command pulses only after a command write
    cmd_pulse_a: assert property (!wr_hit_cmd |=> !command_valid)
        else $error("command pulse without write");

    // Codes from the upper range select other commands
    cmd_other_a: assert property (wr_hit_cmd |=>
        command_other == ($past(reg_wdata) >= `MLCS_CMD_OTHER_MIN))
        else $error("other command class wrong");

    // Codes between the two sets raise neither class
    cmd_gap_a: assert property ((wr_hit_cmd && wclass == mlcs_pkg::MLCS_CMD_BAD) |=>
        !command_fast && !command_other)
        else $error("gap code classed");

    // Position beyond the positive limit trips the violation
    pl_trip_a: assert property ((q.pos_lim != `MLCS_RST_WORD) &&
        ($signed(actual_position) > $signed(q.pos_lim)) |=> limit_violation)
        else $error("positive limit not detected");

    // Position below the negative limit trips the violation
    nl_trip_a: assert property ((q.neg_lim != `MLCS_RST_WORD) &&
        ($signed(actual_position) < $signed(q.neg_lim)) |=> limit_violation)
        else $error("negative limit not detected");

    // Inside both limits no violation
    pl_inside_a: assert property (($signed(actual_position) <= $signed(q.pos_lim)) &&
        ($signed(actual_position) >= $signed(q.neg_lim)) |=> !limit_violation)
        else $error("violation inside limits");

    // Error flags stay until cleared by software
    err_sticky_a: assert property (error_flags[`MLCS_ERR_FLW] &&
        !(reg_wr && idx == `MLCS_IDX_ERR) |=> error_flags[`MLCS_ERR_FLW])
        else $error("follow error flag dropped");

    // Status word ignores writes and keeps sampling
    stat_rdonly_a: assert property ((reg_wr && idx == `MLCS_IDX_STAT) |=>
        q.stat == ($past(motor_status_bits) & `MLCS_STAT_MASK))
        else $error("status word written");

    // Fully masked status keeps the interrupt low
    irq_masked_a: assert property ((q.irq_mk == `MLCS_RST_NIB) &&
        !(reg_wr && idx == `MLCS_IDX_IRQ_MK) |=> !irq)
        else $error("interrupt while masked");

    // Status read clears all bits without a new event
    irq_rdclr_a: assert property (rd_hit_st && (irq_set == `MLCS_RST_NIB) |=>
        q.irq_st == `MLCS_RST_NIB)
        else $error("status not cleared by read");

    fe_trip_c: cover property ($rose(follow_error));
    pl_trip_c: cover property ($rose(limit_violation));
    cmd_bad_c: cover property (wr_hit_cmd && wclass == mlcs_pkg::MLCS_CMD_BAD);
    irq_clr_c: cover property (irq ##1 rd_hit_st ##1 !irq);
    cmd_other_c: cover property (command_other);

endmodule

// ==== test/mlcs_motor_model.sv ====
// Motion side model feeding deviation, position, status and temperature
`timescale 1ns/100ps

module mlcs_motor_model (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [31:0] dev_set,
    input wire logic [31:0] pos_set,
    input wire logic [31:0] stat_set,
    input wire logic [31:0] temp_set,
    output logic [31:0] follow_error_value,
    output logic [31:0] actual_position,
    output logic [31:0] motor_status_bits,
    output logic [31:0] temperature_raw
);
    // Registered sources, as the motion loop updates them each cycle
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            follow_error_value <= 32'h0000_0000;
            actual_position <= 32'h0000_0000;
        end else begin
            follow_error_value <= dev_set;
            actual_position <= pos_set;
        end
        motor_status_bits <= stat_set;
        temperature_raw <= temp_set;
    end
endmodule

// ==== test/tb.sv ====
// Register level testbench for the limit, command and status block
`timescale 1ns/100ps
`include "mlcs_map.svh"

module tb;
    logic clk, sys_rst, reg_wr, reg_rd;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, dev_set, pos_set, stat_set, temp_set;
    logic [31:0] fev, apos, msb, traw, command_code, rv;
    logic follow_error, limit_violation, command_valid, command_fast, command_other, irq;
    logic [3:0] error_flags;
    int fail_count = 0;
    int samples_checked = 0;
    logic [31:0] codes [6] = '{32'h5, 32'h7F, 32'h80, 32'hFF, 32'h100, 32'h1_0000};

    mlcs_core DUT (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .follow_error_value(fev),
        .actual_position(apos), .motor_status_bits(msb), .temperature_raw(traw),
        .follow_error(follow_error), .limit_violation(limit_violation),
        .command_code(command_code), .command_valid(command_valid),
        .command_fast(command_fast), .command_other(command_other),
        .error_flags(error_flags), .irq(irq));
    mlcs_motor_model MOT (.clk(clk), .sys_rst(sys_rst), .dev_set(dev_set), .pos_set(pos_set),
        .stat_set(stat_set), .temp_set(temp_set), .follow_error_value(fev),
        .actual_position(apos), .motor_status_bits(msb), .temperature_raw(traw));

    // Clock at 200 MHz
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic end_of_test();
        if (fail_count == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask

    // One cycle write strobe, entered just after an edge
    task automatic wr(input logic [5:0] idx, input logic [31:0] d);
        reg_addr <= {idx, 2'b00};
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rchk(input string n, input logic [5:0] idx, input logic [31:0] e);
        reg_addr <= {idx, 2'b00};
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk(n, e, reg_rdata);
    endtask

    task automatic settle();
        repeat (4) @(posedge clk);
        #1;
    endtask

    // Watchdog against a hang
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        end_of_test();
    end

    // Main sequence
    initial begin
        {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        {dev_set, pos_set, stat_set, temp_set} = '0;
        sys_rst = 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        rchk("fe_lim", `MLCS_IDX_FE_LIM, 32'h0);
        rchk("cmd", `MLCS_IDX_CMD, 32'h0);
        rchk("neg", `MLCS_IDX_NEG_LIM, 32'h0);
        rchk("pos", `MLCS_IDX_POS_LIM, 32'h0);
        rchk("unmapped", 6'h00, 32'h0);
        // Hi-word slots and read-only status ignore writes
        wr(`MLCS_IDX_FE_LIM_HI, 32'hFFFF_FFFF);
        wr(`MLCS_IDX_NEG_LIM_HI, 32'hFFFF_FFFF);
        wr(`MLCS_IDX_POS_LIM_HI, 32'hFFFF_FFFF);
        wr(`MLCS_IDX_STAT, 32'hFFFF_FFFF);
        rchk("fe_hi", `MLCS_IDX_FE_LIM_HI, 32'h0);
        rchk("neg_hi", `MLCS_IDX_NEG_LIM_HI, 32'h0);
        rchk("pos_hi", `MLCS_IDX_POS_LIM_HI, 32'h0);
        rchk("fe_lim_lo", `MLCS_IDX_FE_LIM, 32'h0);
        // Status masking and temperature
        stat_set <= 32'hFFFF_FFFF;
        temp_set <= 32'h0000_0123;
        settle();
        rchk("stat_all", `MLCS_IDX_STAT, 32'h01FF_C3FE);
        rchk("temp", `MLCS_IDX_TEMP, 32'h0000_0123);
        stat_set <= 32'hFE00_3C01;
        settle();
        rchk("stat_rsvd", `MLCS_IDX_STAT, 32'h0);
        // Soft limits, each read straight after its write
        wr(`MLCS_IDX_NEG_LIM, 32'hFFFF_FF9C);
        rchk("neg", `MLCS_IDX_NEG_LIM, 32'hFFFF_FF9C);
        wr(`MLCS_IDX_POS_LIM, 32'h0000_0064);
        rchk("pos", `MLCS_IDX_POS_LIM, 32'h0000_0064);
        pos_set <= 32'h0000_0064;
        settle();
        chk("lv_edge", 32'h0, limit_violation);
        pos_set <= 32'h0000_0065;
        settle();
        chk("lv_pos", 32'h1, limit_violation);
        chk("err_pos", 32'h9, error_flags);
        pos_set <= 32'hFFFF_FF9B;
        settle();
        chk("lv_neg", 32'h1, limit_violation);
        pos_set <= 32'h0;
        settle();
        wr(`MLCS_IDX_ERR, 32'hF);
        rchk("err_clr", `MLCS_IDX_ERR, 32'h0);
        // Follow error
        dev_set <= 32'h7FFF_FFFF;
        settle();
        chk("fe_off", 32'h0, follow_error);
        wr(`MLCS_IDX_FE_LIM, 32'h0000_000A);
        dev_set <= 32'hFFFF_FFF5;
        settle();
        chk("fe_neg", 32'h1, follow_error);
        chk("err_fe", 32'h3, error_flags);
        dev_set <= 32'h0000_000A;
        settle();
        chk("fe_edge", 32'h0, follow_error);
        // Interrupt: clear, mask, raise, read-clear
        rchk("irq_st", `MLCS_IDX_IRQ_ST, 32'h3);
        wr(`MLCS_IDX_IRQ_MK, 32'h1);
        chk("irq_idle", 32'h0, irq);
        rchk("irq_mk", `MLCS_IDX_IRQ_MK, 32'h1);
        dev_set <= 32'hFFFF_FFEC;
        settle();
        chk("irq_on", 32'h1, irq);
        rchk("irq_st1", `MLCS_IDX_IRQ_ST, 32'h1);
        settle();
        chk("irq_off", 32'h0, irq);
        // Command codes across both sets and the gap
        foreach (codes[i]) begin
            wr(`MLCS_IDX_CMD, codes[i]);
            chk("cmd_valid", 32'h1, command_valid);
            chk("cmd_fast", {31'h0, codes[i] <= 32'h7F}, command_fast);
            chk("cmd_other", {31'h0, codes[i] >= 32'h100}, command_other);
            chk("cmd_code", codes[i], command_code);
        end
        rchk("cmd_rd", `MLCS_IDX_CMD, 32'h1_0000);
        rchk("irq_st_cmd", `MLCS_IDX_IRQ_ST, 32'hC);
        // Negative follow limit trips on any deviation
        dev_set <= 32'h0;
        settle();
        chk("fe_small", 32'h0, follow_error);
        wr(`MLCS_IDX_FE_LIM, 32'hFFFF_FFFF);
        settle();
        chk("fe_neglim", 32'h1, follow_error);
        end_of_test();
    end
endmodule
